// ### logic/touch_calibration_keyfilter.sv
// Purpose: touch back end: median filter, calibration, touch and key filter, proximity
// Assumes: one front-end sample per pulse, same clock; byte register port
// Notes: per-channel state lives in arrays indexed by channel number
`timescale 1ns/1ns

// Operation
// - multiplier codes decode to 8, 32, 128, 512
// - calibration period is interval x 10 ms x multiplier
// - samples in an event spaced (spacing + 1) x 10 ms, at least 20 ms
// - model 00 normal, 10 auto-tuning, others reserved
// - auto-tuning blocks host delay writes, tunes out-of-range
// - calibration mode bit 0 enables auto-calibration
// - median modes: 10/2, 18/2, 20/4 samples
// - median filter bit 0 enables the filter
// - data selector picks what channel ports show
// - channel N at 0xC0+2N low, high next
// - touched when drop exceeds touch threshold
// - small change adjusts calibrated reference impedance
// - channel delay is 6 bits, 0.5 pF steps
// - live impedance falls as capacitance rises
// - impedance 13 bits, low 4 internal
// - reference impedance updated at each calibration
// - locked code captures one set, then frozen
// - proximity channel field picks one of 16
// - proximity enable bit starts proximity sensing
// - key filter keeps 1-3 largest group changes of channels 0-22
// - group mask bits select key filter members
// - proximity dithering factor 4x to 32x
// - touched threshold lowers by four times hysteresis
// - relock needs a different code written first
// - each calibration averages eight impedance samples
module touch_calibration_keyfilter #(
	parameter int TICK_CYCLES = touch_pkg::TEN_MS_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	// front-end samples
	input wire logic sampleValid,
	input wire logic [4:0] sampleChannel,
	input wire logic [8:0] sampleValue,
	// status to the rest of the chip
	output logic [touch_pkg::NCH-1:0] touchStatus,
	output logic [touch_pkg::NCH-1:0] filteredKeys,
	output logic [touch_pkg::NCH*6-1:0] channelDelay
);
	import touch_pkg::*;

	logic [7:0] calInterval_q, calMode_q, medianCfg_q, dataSel_q, sensorCtrl_q;
	logic [7:0] keyProxCtrl_q, proxCfg_q, proxTouchThr_q, proxEnvThr_q;
	logic [23:0] groupMask_q;
	logic [8:0] touchThr [NCH];
	logic [8:0] envThr [NCH];
	logic [5:0] delay [NCH];
	logic [12:0] impedance [NCH];
	logic [12:0] reference [NCH];
	logic [12:0] locked [NCH];
	logic [13:0] medSum [NCH];
	logic [8:0] medMin [NCH];
	logic [8:0] medMax [NCH];
	logic [8:0] medMin2 [NCH];
	logic [8:0] medMax2 [NCH];
	logic [4:0] medCnt [NCH];
	logic [15:0] calAcc [NCH];

	logic wrHit, chWr, chHigh;
	logic [4:0] chIdx;
	logic [7:0] chOffset;
	assign chOffset = regAddr - ADDR_CH_DATA_FIRST;
	assign chIdx = chOffset[5:1];
	assign chHigh = chOffset[0];
	assign wrHit = regWrEn;
	assign chWr = regWrEn && regAddr >= ADDR_CH_DATA_FIRST && regAddr <= ADDR_CH_DATA_LAST;

	// control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			calInterval_q <= RESET_BYTE;
			calMode_q <= RESET_BYTE;
			medianCfg_q <= RESET_BYTE;
			dataSel_q <= RESET_BYTE;
			sensorCtrl_q <= RESET_BYTE;
			keyProxCtrl_q <= RESET_BYTE;
			proxCfg_q <= RESET_BYTE;
			proxTouchThr_q <= RESET_BYTE;
			proxEnvThr_q <= RESET_BYTE;
			groupMask_q <= RESET_MASK;
		end else if (wrHit) begin
			case (regAddr)
				ADDR_CAL_INTERVAL: calInterval_q <= regWrData;
				ADDR_CAL_MODE: calMode_q <= regWrData;
				ADDR_MEDIAN_CFG: medianCfg_q <= regWrData;
				ADDR_DATA_SEL: dataSel_q <= regWrData;
				ADDR_SENSOR_CTRL: sensorCtrl_q <= regWrData;
				ADDR_KEY_PROX_CTRL: keyProxCtrl_q <= regWrData;
				ADDR_GROUP_MASK: groupMask_q[7:0] <= regWrData;
				ADDR_GROUP_MASK + 8'h01: groupMask_q[15:8] <= regWrData;
				ADDR_GROUP_MASK + 8'h02: groupMask_q[23:16] <= regWrData;
				ADDR_PROX_CFG: proxCfg_q <= regWrData;
				ADDR_PROX_TOUCH_THR: proxTouchThr_q <= regWrData;
				ADDR_PROX_ENV_THR: proxEnvThr_q <= regWrData;
				default: ;
			endcase
		end
	end

	// 10 ms time base
	logic [31:0] tickCnt;
	logic tick;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tickCnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (tickCnt == 32'(TICK_CYCLES - 1));
			tickCnt <= (tickCnt == 32'(TICK_CYCLES - 1)) ? '0 : tickCnt + 32'h1;
		end
	end

	// calibration period and sampling
	logic [9:0] multiplier;
	logic [15:0] periodTicks;
	always_comb begin
		case (calInterval_q[7:MULT_LSB])
			2'h0: multiplier = 10'h008;
			2'h1: multiplier = 10'h020;
			2'h2: multiplier = 10'h080;
			default: multiplier = 10'h200;
		endcase
		periodTicks = 16'(calInterval_q[INTERVAL_MSB:0] * multiplier);
	end

	cal_state_t calState;
	logic [15:0] periodCnt;
	logic [4:0] spaceCnt;
	logic [3:0] calTaken;
	logic calDone;
	logic calEnable;
	assign calEnable = calMode_q[0];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			calState <= CAL_IDLE;
			periodCnt <= '0;
			spaceCnt <= '0;
			calTaken <= '0;
			calDone <= 1'b0;
		end else begin
			calDone <= 1'b0;
			if (!calEnable || periodTicks == 16'h0) begin
				calState <= CAL_IDLE;
				periodCnt <= '0;
			end else if (tick) begin
				periodCnt <= (periodCnt >= periodTicks - 16'h1) ? '0 : periodCnt + 16'h1;
				case (calState)
					CAL_IDLE: begin
						if (periodCnt >= periodTicks - 16'h1) begin
							calState <= CAL_TAKE;
							calTaken <= '0;
						end
					end
					CAL_WAIT: begin
						if (spaceCnt + 5'h1 >= calMode_q[7:SPACING_LSB]) begin
							calState <= CAL_TAKE;
						end
						spaceCnt <= spaceCnt + 5'h1;
					end
					CAL_TAKE: begin
						spaceCnt <= '0;
						calTaken <= calTaken + 4'h1;
						if (calTaken == 4'(CAL_SAMPLES - 1)) begin
							calState <= CAL_IDLE;
							calDone <= 1'b1;
						end else begin
							calState <= CAL_WAIT;
						end
					end
					default: calState <= CAL_IDLE;
				endcase
			end
		end
	end

	// eight-sample averaging per channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) calAcc[i] <= '0;
		end else if (tick && calState == CAL_TAKE && calEnable) begin
			for (int i = 0; i < NCH; i++) begin
				calAcc[i] <= (calTaken == 4'h0) ? 16'(impedance[i])
					: calAcc[i] + 16'(impedance[i]);
			end
		end
	end

	// median filter and live impedance
	logic [4:0] medTarget;
	logic [13:0] medKept;
	logic [12:0] medResult;
	logic [4:0] sc;
	assign sc = sampleChannel;
	always_comb begin
		case (medianCfg_q[2:1])
			2'h1: medTarget = 5'd18;
			2'h2: medTarget = 5'd20;
			default: medTarget = 5'd10;
		endcase
		medKept = medSum[sc] + 14'(sampleValue) - 14'(medMin[sc]) - 14'(medMax[sc]);
		if (sampleValue < medMin[sc]) medKept = medSum[sc] - 14'(medMax[sc]);
		if (sampleValue > medMax[sc]) medKept = medSum[sc] - 14'(medMin[sc]);
		if (medianCfg_q[2:1] == 2'h2) begin
			// second extremes tracked so exactly two drop at each end
			medKept = medSum[sc] + 14'(sampleValue) - 14'(medMin[sc]) - 14'(medMax[sc])
				- 14'(sampleValue < medMin2[sc] ? sampleValue : medMin2[sc])
				- 14'(sampleValue > medMax2[sc] ? sampleValue : medMax2[sc]);
			medResult = medKept[12:0];
		end else if (medianCfg_q[2:1] == 2'h1) begin
			medResult = medKept[12:0];
		end else begin
			medResult = {medKept[11:0], 1'b0};
		end
	end

	logic impNew;
	logic [4:0] impCh;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			impNew <= 1'b0;
			impCh <= '0;
			for (int i = 0; i < NCH; i++) begin
				impedance[i] <= '0;
				medSum[i] <= '0;
				medCnt[i] <= '0;
				medMin[i] <= RAW_MAX;
				medMax[i] <= RAW_MIN;
				medMin2[i] <= RAW_MAX;
				medMax2[i] <= RAW_MIN;
			end
		end else begin
			impNew <= 1'b0;
			if (sampleValid && sc < 5'(NCH)) begin
				impCh <= sc;
				if (!medianCfg_q[0]) begin
					impedance[sc] <= {sampleValue, 4'h0};
					impNew <= 1'b1;
				end else if (medCnt[sc] + 5'h1 >= medTarget) begin
					impedance[sc] <= medResult;
					impNew <= 1'b1;
					medSum[sc] <= '0;
					medCnt[sc] <= '0;
					medMin[sc] <= RAW_MAX;
					medMax[sc] <= RAW_MIN;
					medMin2[sc] <= RAW_MAX;
					medMax2[sc] <= RAW_MIN;
				end else begin
					medSum[sc] <= medSum[sc] + 14'(sampleValue);
					medCnt[sc] <= medCnt[sc] + 5'h1;
					if (sampleValue < medMin[sc]) medMin[sc] <= sampleValue;
					if (sampleValue > medMax[sc]) medMax[sc] <= sampleValue;
					if (sampleValue < medMin[sc]) medMin2[sc] <= medMin[sc];
					else if (sampleValue < medMin2[sc]) medMin2[sc] <= sampleValue;
					if (sampleValue > medMax[sc]) medMax2[sc] <= medMax[sc];
					else if (sampleValue > medMax2[sc]) medMax2[sc] <= sampleValue;
				end
			end
		end
	end

	// reference impedance and touch decision
	logic [12:0] drop, absDiff, touchLimit;
	logic [8:0] hysLimit;
	always_comb begin
		drop = reference[impCh] - impedance[impCh];
		absDiff = (reference[impCh] > impedance[impCh]) ? drop
			: impedance[impCh] - reference[impCh];
		hysLimit = touchThr[impCh] - {1'b0, sensorCtrl_q[6:HYS_LSB], 2'h0};
		if (touchThr[impCh] < {1'b0, sensorCtrl_q[6:HYS_LSB], 2'h0}) hysLimit = '0;
		touchLimit = touchStatus[impCh] ? {hysLimit, 4'h0} : {touchThr[impCh], 4'h0};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			touchStatus <= '0;
			for (int i = 0; i < NCH; i++) reference[i] <= '0;
		end else begin
			if (calDone) begin
				for (int i = 0; i < NCH; i++) reference[i] <= calAcc[i][15:3];
			end else if (impNew && absDiff < {envThr[impCh], 4'h0}) begin
				// one step per sample keeps slow drift from masking a real touch
				reference[impCh] <= (reference[impCh] > impedance[impCh])
					? reference[impCh] - 13'h1 : reference[impCh] + 13'h1;
			end
			if (impNew) begin
				touchStatus[impCh] <= (reference[impCh] > impedance[impCh])
					&& drop > touchLimit;
			end
		end
	end

	// per-channel thresholds and delay
	logic autoTune;
	assign autoTune = calMode_q[2:MODEL_LSB] == MODEL_AUTOTUNE;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				touchThr[i] <= '0;
				envThr[i] <= '0;
				delay[i] <= '0;
			end
		end else begin
			if (chWr && dataSel_q == SEL_TOUCH_THR) begin
				if (chHigh) touchThr[chIdx][8] <= regWrData[0];
				else touchThr[chIdx][7:0] <= regWrData;
			end
			if (chWr && dataSel_q == SEL_ENV_THR) begin
				if (chHigh) envThr[chIdx][8] <= regWrData[0];
				else envThr[chIdx][7:0] <= regWrData;
			end
			if (chWr && dataSel_q == SEL_DELAY && !chHigh && !autoTune) begin
				delay[chIdx] <= regWrData[5:0];
			end
			if (autoTune && sampleValid && sc < 5'(NCH)) begin
				if (sampleValue == RAW_MIN && delay[sc] != 6'h3f) delay[sc] <= delay[sc] + 6'h1;
				if (sampleValue == RAW_MAX && delay[sc] != 6'h00) delay[sc] <= delay[sc] - 6'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) channelDelay <= '0;
		else for (int i = 0; i < NCH; i++) channelDelay[i*6 +: 6] <= delay[i];
	end

	// locked set, refreshed only on entry to the locked code
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) locked[i] <= '0;
		end else if (wrHit && regAddr == ADDR_DATA_SEL && regWrData == SEL_LOCKED
				&& dataSel_q != SEL_LOCKED) begin
			for (int i = 0; i < NCH; i++) locked[i] <= impedance[i];
		end
	end

	// key filter: scans channels 0 to 22, one per cycle, keeps the three largest drops
	logic [4:0] scanIdx;
	logic [12:0] best [3];
	logic [4:0] bestIdx [3];
	logic [2:0] bestOk;
	logic [12:0] scanDrop;
	logic scanCand;
	assign scanDrop = (reference[scanIdx] > impedance[scanIdx])
		? reference[scanIdx] - impedance[scanIdx] : 13'h0;
	assign scanCand = touchStatus[scanIdx] && groupMask_q[scanIdx];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scanIdx <= '0;
			bestOk <= '0;
			filteredKeys <= '0;
			for (int k = 0; k < 3; k++) begin
				best[k] <= '0;
				bestIdx[k] <= '0;
			end
		end else if (scanIdx == 5'(NCH - 1)) begin
			scanIdx <= '0;
			bestOk <= '0;
			filteredKeys <= touchStatus & ~groupMask_q;
			for (int k = 0; k < 3; k++) begin
				if (bestOk[k] && (keyProxCtrl_q[1:0] == 2'h0 || k < int'(keyProxCtrl_q[1:0])))
					filteredKeys[bestIdx[k]] <= 1'b1;
			end
			if (keyProxCtrl_q[1:0] == 2'h0) filteredKeys <= touchStatus;
		end else begin
			scanIdx <= scanIdx + 5'h1;
			if (scanCand) begin
				if (!bestOk[0] || scanDrop > best[0]) begin
					best[0] <= scanDrop;
					bestIdx[0] <= scanIdx;
					best[1] <= best[0];
					bestIdx[1] <= bestIdx[0];
					best[2] <= best[1];
					bestIdx[2] <= bestIdx[1];
					bestOk <= {bestOk[1:0], 1'b1};
				end else if (!bestOk[1] || scanDrop > best[1]) begin
					best[1] <= scanDrop;
					bestIdx[1] <= scanIdx;
					best[2] <= best[1];
					bestIdx[2] <= bestIdx[1];
					bestOk <= {bestOk[1], 2'h3};
				end else if (!bestOk[2] || scanDrop > best[2]) begin
					best[2] <= scanDrop;
					bestIdx[2] <= scanIdx;
					bestOk <= 3'h7;
				end
			end
		end
	end

	// proximity: dithered accumulation on the chosen channel
	logic [14:0] proxAcc;
	logic [5:0] proxCnt, proxFactor;
	logic [12:0] proxImp, proxRef, proxShown;
	logic [17:0] proxScaled;
	logic proxDone, proxNear, proxCalDone;
	assign proxFactor = 6'h04 << proxCfg_q[7:DITHER_LSB];
	assign proxScaled = {proxAcc + 15'(sampleValue), 3'h0} >> proxCfg_q[7:DITHER_LSB];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			proxAcc <= '0;
			proxCnt <= '0;
			proxImp <= '0;
			proxRef <= '0;
			proxNear <= 1'b0;
			proxCalDone <= 1'b0;
		end else begin
			if (wrHit && regAddr == ADDR_PROX_ENV_THR && regWrData[FORCE_CAL_BIT])
				proxCalDone <= 1'b0;
			if (keyProxCtrl_q[PROX_EN_BIT] && sampleValid
					&& sc == {1'b0, keyProxCtrl_q[7:PROX_SEL_LSB]}) begin
				if (proxCnt + 6'h1 >= proxFactor) begin
					proxAcc <= '0;
					proxCnt <= '0;
					proxImp <= proxScaled[12:0];
					proxNear <= proxRef > proxScaled[12:0]
						&& proxRef - proxScaled[12:0] > {1'b0, proxTouchThr_q, 4'h0};
					if (proxEnvThr_q[FORCE_CAL_BIT]) begin
						proxRef <= proxScaled[12:0];
						proxCalDone <= 1'b1;
					end
				end else begin
					proxAcc <= proxAcc + 15'(sampleValue);
					proxCnt <= proxCnt + 6'h1;
				end
			end
		end
	end
	assign proxShown = proxCfg_q[0] ? proxRef : proxImp;

	// read path
	logic [15:0] chWord;
	logic [7:0] rdMux;
	always_comb begin
		case (dataSel_q)
			SEL_TOUCH_THR: chWord = {7'h0, touchThr[chIdx]};
			SEL_ENV_THR: chWord = {7'h0, envThr[chIdx]};
			SEL_DELAY: chWord = {10'h0, delay[chIdx]};
			SEL_IMPEDANCE: chWord = {3'h0, impedance[chIdx]};
			SEL_CALIBRATED: chWord = {3'h0, reference[chIdx]};
			SEL_LOCKED: chWord = {3'h0, locked[chIdx]};
			default: chWord = 16'h0000;
		endcase
		case (regAddr)
			ADDR_CAL_INTERVAL: rdMux = calInterval_q;
			ADDR_CAL_MODE: rdMux = calMode_q;
			ADDR_MEDIAN_CFG: rdMux = medianCfg_q;
			ADDR_DATA_SEL: rdMux = dataSel_q;
			ADDR_SENSOR_CTRL: rdMux = sensorCtrl_q;
			ADDR_KEY_PROX_CTRL: rdMux = keyProxCtrl_q;
			ADDR_GROUP_MASK: rdMux = groupMask_q[7:0];
			ADDR_GROUP_MASK + 8'h01: rdMux = groupMask_q[15:8];
			ADDR_GROUP_MASK + 8'h02: rdMux = groupMask_q[23:16];
			ADDR_PROX_CFG: rdMux = proxCfg_q;
			ADDR_PROX_TOUCH_THR: rdMux = proxTouchThr_q;
			ADDR_PROX_ENV_THR: rdMux = proxEnvThr_q;
			ADDR_FILTERED_KEYS: rdMux = filteredKeys[7:0];
			ADDR_FILTERED_KEYS + 8'h01: rdMux = filteredKeys[15:8];
			ADDR_FILTERED_KEYS + 8'h02: rdMux = filteredKeys[23:16];
			ADDR_PROX_DATA_LO: rdMux = proxShown[7:0];
			ADDR_PROX_DATA_HI: rdMux = {proxNear, proxCalDone, 1'b0, proxShown[12:8]};
			ADDR_TOUCH_STATUS: rdMux = touchStatus[7:0];
			ADDR_TOUCH_STATUS + 8'h01: rdMux = touchStatus[15:8];
			ADDR_TOUCH_STATUS + 8'h02: rdMux = touchStatus[23:16];
			default: rdMux = 8'h00;
		endcase
		if (regAddr >= ADDR_CH_DATA_FIRST && regAddr <= ADDR_CH_DATA_LAST)
			rdMux = chHigh ? chWord[15:8] : chWord[7:0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) regRdData <= 8'h00;
		else if (regRdEn) regRdData <= rdMux;
	end
endmodule // touch_calibration_keyfilter

// ### logic/touch_pkg.sv
// Purpose: shared constants for the touch calibration and key filter block
// Assumes: 125 MHz clock, byte-wide register port behind the serial host link
// Notes: register offsets are byte addresses
package touch_pkg;
	localparam int NCH = 24;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TEN_MS_NS = 10000000;
	// rounding: floor, so the tick is never longer than 10 ms
	localparam int TEN_MS_CYCLES = TEN_MS_NS / CLK_PERIOD_NS;

	// register offsets
	localparam logic [7:0] ADDR_CAL_INTERVAL = 8'h76;
	localparam logic [7:0] ADDR_CAL_MODE = 8'h77;
	localparam logic [7:0] ADDR_MEDIAN_CFG = 8'h78;
	localparam logic [7:0] ADDR_DATA_SEL = 8'h7c;
	localparam logic [7:0] ADDR_KEY_PROX_CTRL = 8'h90;
	localparam logic [7:0] ADDR_GROUP_MASK = 8'h92;
	localparam logic [7:0] ADDR_PROX_CFG = 8'h96;
	localparam logic [7:0] ADDR_PROX_TOUCH_THR = 8'h97;
	localparam logic [7:0] ADDR_PROX_ENV_THR = 8'h98;
	localparam logic [7:0] ADDR_FILTERED_KEYS = 8'h9a;
	localparam logic [7:0] ADDR_PROX_DATA_LO = 8'hb0;
	localparam logic [7:0] ADDR_PROX_DATA_HI = 8'hb1;
	localparam logic [7:0] ADDR_TOUCH_STATUS = 8'hb4;
	localparam logic [7:0] ADDR_CH_DATA_FIRST = 8'hc0;
	localparam logic [7:0] ADDR_CH_DATA_LAST = 8'hef;
	localparam logic [7:0] ADDR_SENSOR_CTRL = 8'h70;

	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [23:0] RESET_MASK = 24'h000000;

	// field positions
	localparam int MULT_LSB = 6;
	localparam int INTERVAL_MSB = 5;
	localparam int SPACING_LSB = 3;
	localparam int MODEL_LSB = 1;
	localparam int PROX_SEL_LSB = 4;
	localparam int PROX_EN_BIT = 2;
	localparam int HYS_LSB = 1;
	localparam int DITHER_LSB = 6;
	localparam int FORCE_CAL_BIT = 7;

	// codes
	localparam logic [1:0] MODEL_NORMAL = 2'h0;
	localparam logic [1:0] MODEL_AUTOTUNE = 2'h2;
	localparam logic [7:0] SEL_TOUCH_THR = 8'h01;
	localparam logic [7:0] SEL_ENV_THR = 8'h02;
	localparam logic [7:0] SEL_DELAY = 8'h03;
	localparam logic [7:0] SEL_IMPEDANCE = 8'h04;
	localparam logic [7:0] SEL_CALIBRATED = 8'h05;
	localparam logic [7:0] SEL_LOCKED = 8'h06;

	localparam int CAL_SAMPLES = 8;
	localparam int IMP_FRAC_BITS = 4;
	localparam logic [8:0] RAW_MAX = 9'h1ff;
	localparam logic [8:0] RAW_MIN = 9'h000;

	typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT, CAL_TAKE} cal_state_t;
endpackage

// ### testbench/host_model.sv
// Purpose: host side of the register port
// Assumes: strobes are one-cycle pulses, read data one cycle later
// Notes: data lines are scrambled once released
`timescale 1ns/1ns
module host_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrEn,
	output logic regRdEn,
	input wire logic [7:0] regRdData
);
	import touch_pkg::*;
	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		regWrData <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		@(posedge clk);
		d = regRdData;
	endtask
	// settings only change with the sensor off; hysteresis 10 rides on enable
	task automatic cfg(input logic [7:0] a, input logic [7:0] d);
		wr(ADDR_SENSOR_CTRL, 8'h14);
		wr(a, d);
		wr(ADDR_SENSOR_CTRL, 8'h94);
	endtask
endmodule // host_model

// ### testbench/testbench.sv
// Purpose: self-checking bench for the touch back end
// Assumes: tick shortened to 4 cycles
// Notes: touch model tracks channels 0 to 3 only
`timescale 1ns/1ns
module testbench;
	import touch_pkg::*;
	localparam int THR = 50;
	localparam int TOUCH_HYSTERESIS_FIELD = 10;
	logic clk;
	logic rst;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic regWrEn;
	logic regRdEn;
	logic [7:0] regRdData;
	logic sampleValid;
	logic [4:0] sampleChannel;
	logic [8:0] sampleValue;
	logic [NCH-1:0] touchStatus;
	logic [NCH-1:0] filteredKeys;
	logic [NCH*6-1:0] channelDelay;
	int errors;
	int total_checks;
	int refI [NCH];
	int impI [NCH];
	logic [NCH-1:0] tch;
	logic [7:0] b;
	logic [7:0] d;
	logic [15:0] w;
	int q [$];
	int lk;
	int tv [4] = '{140, 100, 110, 120};
	int cnt [3] = '{10, 18, 20};
	logic [7:0] regList [14] = '{8'h76, 8'h77, 8'h78, 8'h7c, 8'h90, 8'h92, 8'h93, 8'h94,
		8'h96, 8'h97, 8'h9a, 8'hb0, 8'hb4, 8'h50};
	logic [7:0] rwList [4] = '{8'h92, 8'h96, 8'h97, 8'h50};
	touch_calibration_keyfilter #(.TICK_CYCLES(4)) i_dut (.*);
	host_model i_host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regRdData(regRdData));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic rd16(input int ch, output logic [15:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		i_host.rd(8'(8'hc0 + 2 * ch), lo);
		i_host.rd(8'(8'hc1 + 2 * ch), hi);
		v = {hi, lo};
	endtask
	task automatic wr16(input int ch, input logic [15:0] v);
		i_host.wr(8'(8'hc0 + 2 * ch), v[7:0]);
		i_host.wr(8'(8'hc1 + 2 * ch), v[15:8]);
	endtask
	// model keeps a lowered threshold while a channel stays touched
	task automatic smp(input int ch, input int v);
		int thrEff;
		@(posedge clk);
		sampleValid <= 1'b1;
		sampleChannel <= 5'(ch);
		sampleValue <= 9'(v);
		@(posedge clk);
		sampleValid <= 1'b0;
		sampleValue <= ~9'(v);
		impI[ch] = v * 16;
		thrEff = tch[ch] ? THR - 4 * TOUCH_HYSTERESIS_FIELD : THR;
		tch[ch] = (refI[ch] - impI[ch]) > thrEff * 16;
		repeat (3) @(posedge clk);
	endtask
	// same reference everywhere, so the largest drop is the smallest impedance
	function automatic logic [3:0] keysExp(int k);
		logic [3:0] r;
		int rank;
		for (int i = 0; i < 4; i++) begin
			rank = 0;
			for (int j = 0; j < 4; j++) begin
				if (tch[j] && impI[j] < impI[i]) rank++;
			end
			r[i] = tch[i] && (k == 0 || rank < k);
		end
		return r;
	endfunction
	function automatic int medExp(int m, int s [$]);
		int sum;
		int drop;
		s.sort();
		drop = (m == 2) ? 2 : 1;
		sum = 0;
		for (int i = drop; i < s.size() - drop; i++) sum += s[i];
		return (m == 0) ? sum * 2 : sum;
	endfunction
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		sampleValid = 1'b0;
		sampleChannel = 5'h00;
		sampleValue = 9'h000;
		tch = '0;
		void'($urandom(32881));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (regList[i]) begin
			i_host.rd(regList[i], b);
			chk(b, 8'h00);
		end
		foreach (rwList[i]) begin
			d = 8'($urandom());
			i_host.wr(rwList[i], d);
			i_host.rd(rwList[i], b);
			chk(b, (rwList[i] == 8'h50) ? 8'h00 : d);
		end
		i_host.wr(ADDR_DATA_SEL, SEL_TOUCH_THR);
		for (int i = 0; i < 4; i++) wr16(i, 16'(THR));
		wr16(23, 16'hffff);
		rd16(23, w);
		chk(w, 16'h01ff);
		rd16(0, w);
		chk(w, 16'(THR));
		i_host.wr(ADDR_DATA_SEL, SEL_DELAY);
		wr16(23, 16'hffff);
		rd16(23, w);
		chk(w, 16'h003f);
		chk(channelDelay[143:138], 6'h3f);
		i_host.wr(ADDR_CAL_MODE, 8'h04);
		wr16(23, 16'h0005);
		rd16(23, w);
		chk(w, 16'h003f);
		i_host.wr(ADDR_CAL_INTERVAL, 8'hc1);
		i_host.wr(ADDR_CAL_MODE, 8'h01);
		i_host.wr(ADDR_GROUP_MASK, 8'h0f);
		i_host.wr(ADDR_SENSOR_CTRL, 8'h94);
		i_host.wr(ADDR_DATA_SEL, SEL_IMPEDANCE);
		for (int i = 0; i < 5; i++) begin
			smp(i, (i < 4) ? 200 : int'($urandom_range(511)));
			rd16(i, w);
			chk(w, 16'(impI[i]));
		end
		i_host.wr(ADDR_DATA_SEL, SEL_CALIBRATED);
		w = 16'h0000;
		for (int n = 0; n < 400 && w !== 16'd3200; n++) begin
			repeat (8) @(posedge clk);
			rd16(3, w);
		end
		for (int i = 0; i < 5; i++) begin
			refI[i] = impI[i];
			rd16(i, w);
			chk(w, 16'(refI[i]));
		end
		for (int i = 0; i < 4; i++) begin
			smp(i, tv[i]);
			chk(touchStatus, {20'h0, tch[3:0]});
		end
		i_host.rd(ADDR_TOUCH_STATUS, b);
		chk(b, {4'h0, tch[3:0]});
		for (int k = 0; k < 4; k++) begin
			i_host.cfg(ADDR_KEY_PROX_CTRL, 8'(k));
			repeat (30) @(posedge clk);
			chk(filteredKeys, {20'h0, keysExp(k)});
			i_host.rd(ADDR_FILTERED_KEYS, b);
			chk(b, {4'h0, keysExp(k)});
		end
		smp(2, 185);
		chk(touchStatus, {20'h0, tch[3:0]});
		smp(2, 195);
		chk(touchStatus, {20'h0, tch[3:0]});
		lk = impI[2];
		i_host.wr(ADDR_DATA_SEL, SEL_LOCKED);
		smp(2, 200);
		rd16(2, w);
		chk(w, 16'(lk));
		i_host.wr(ADDR_DATA_SEL, 8'h00);
		i_host.wr(ADDR_DATA_SEL, SEL_LOCKED);
		rd16(2, w);
		chk(w, 16'(impI[2]));
		i_host.wr(ADDR_DATA_SEL, SEL_IMPEDANCE);
		for (int m = 0; m < 3; m++) begin
			i_host.cfg(ADDR_MEDIAN_CFG, 8'(m * 2 + 1));
			q.delete();
			for (int n = 0; n < cnt[m]; n++) begin
				q.push_back(int'($urandom_range(511)));
				smp(8 + m, q[$]);
			end
			rd16(8 + m, w);
			chk(w, 16'(medExp(m, q)));
		end
		print_verdict();
	end
endmodule // testbench

// ### testbench/touch_chk.sv
// Purpose: port-level checks for the touch back end
// Assumes: one clock, asynchronous active-high reset
// Notes: selector and model are shadowed from register writes
`timescale 1ns/1ns
module touch_chk #(
	parameter int TICK_CYCLES = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regRdData,
	// samples and status
	input wire logic sampleValid,
	input wire logic [4:0] sampleChannel,
	input wire logic [8:0] sampleValue,
	input wire logic [touch_pkg::NCH-1:0] touchStatus,
	input wire logic [touch_pkg::NCH-1:0] filteredKeys,
	input wire logic [touch_pkg::NCH*6-1:0] channelDelay
);
	import touch_pkg::*;
	logic [7:0] selQ;
	logic [1:0] modelQ;
	logic [4:0] chQ;
	logic [5:0] lastDelay;
	logic lowPort;
	// shadows let the checker know when a delay write must land
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			selQ <= 8'h00;
			modelQ <= 2'h0;
		end else if (regWrEn && regAddr == ADDR_DATA_SEL) begin
			selQ <= regWrData;
		end else if (regWrEn && regAddr == ADDR_CAL_MODE) begin
			modelQ <= regWrData[2:1];
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chQ <= 5'h00;
		end else begin
			chQ <= 5'((regAddr - ADDR_CH_DATA_FIRST) >> 1);
		end
	end
	assign lowPort = regAddr >= ADDR_CH_DATA_FIRST && regAddr <= ADDR_CH_DATA_LAST && !regAddr[0];
	assign lastDelay = channelDelay[6*chQ +: 6];
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	read_hold_a: assert property (
		!regRdEn |=> $stable(regRdData)) else $error("read data moved without a read");
	unmapped_read_a: assert property (
		regRdEn && regAddr == 8'h50 |=> regRdData == 8'h00) else $error("unmapped read not zero");
	touch_read_a: assert property (
		regRdEn && regAddr == ADDR_TOUCH_STATUS |=> regRdData == $past(touchStatus[7:0]))
		else $error("touch status read wrong");
	key_read_a: assert property (
		regRdEn && regAddr == ADDR_FILTERED_KEYS |=> regRdData == $past(filteredKeys[7:0]))
		else $error("filtered key read wrong");
	touch_cause_a: assert property (
		$changed(touchStatus) |-> $past(sampleValid, 2)) else $error("touch moved without sample");
	delay_cause_a: assert property (
		$changed(channelDelay) |-> $past(regWrEn, 2) || $past(sampleValid) || $past(sampleValid, 2))
		else $error("delay moved without cause");
	delay_write_a: assert property (
		regWrEn && lowPort && selQ == SEL_DELAY && modelQ != MODEL_AUTOTUNE
		|=> ##1 lastDelay == $past(regWrData[5:0], 2)) else $error("delay write not taken");
	delay_lock_a: assert property (
		regWrEn && lowPort && modelQ == MODEL_AUTOTUNE && !sampleValid && !$past(sampleValid)
		|=> ##1 $stable(channelDelay)) else $error("delay write taken in auto-tune");
	reset_quiet_a: assert property (disable iff (1'b0)
		rst |-> touchStatus == '0 && filteredKeys == '0 && channelDelay == '0 && regRdData == 8'h00)
		else $error("outputs not cleared in reset");
	cover property (touchStatus[2] ##1 !touchStatus[2]);
	cover property (filteredKeys != '0 && filteredKeys != touchStatus);
	cover property (regWrEn && lowPort && selQ == SEL_DELAY);
endmodule // touch_chk

bind touch_calibration_keyfilter touch_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);
